// ==== bench/cfs_seq_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module cfs_seq_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Control port
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic [7:0] cmd_wdata,
    input wire logic [7:0] rd_data_q,
    input wire logic rd_valid_q,
    // Modulator side
    input wire logic bit_tick,
    input wire logic tx_bit_q,
    input wire logic tx_on_q,
    input wire logic [3:0] chan_route_q,
    input wire logic spec_sel_q,
    input wire logic busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire rd_c = cmd_valid && !cmd_byte[7];
    wire wr_ctl = cmd_valid && cmd_byte == 8'hB0;
    rd_answer_a: assert property (rd_c |=> rd_valid_q) else $error("read not answered");
    wr_silent_a: assert property (cmd_valid && cmd_byte[7] |=> !rd_valid_q)
        else $error("write answered as read");
    unmapped_zero_a: assert property (rd_c && (cmd_byte[6:0] < 7'h2C || cmd_byte[6:0] > 7'h30)
        |=> rd_data_q == 8'h00) else $error("unmapped read not zero");
    rd_hold_a: assert property (!rd_valid_q |-> $stable(rd_data_q)) else $error("read data moved");
    route_hot_a: assert property (tx_on_q |-> $onehot(chan_route_q)) else $error("bad route");
    idle_mute_a: assert property (!busy ##1 !busy |-> !tx_on_q && chan_route_q == 4'h0)
        else $error("output live while idle");
    bit_hold_a: assert property (tx_on_q && !bit_tick && !$past(bit_tick) |-> $stable(tx_bit_q))
        else $error("bit changed without tick");
    disable_off_a: assert property (wr_ctl && !cmd_wdata[3] |-> ##[2:3] !tx_on_q)
        else $error("disabled block still sending");
    spec_copy_a: assert property (wr_ctl |-> ##2 spec_sel_q == $past(cmd_wdata[2], 2))
        else $error("spec select not followed");
endmodule
`default_nettype wire

// ==== bench/cfs_tick_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Modulator stand-in: one tick per bit period; a longer period models a slow modulator.
module cfs_tick_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] period,
    output logic bit_tick
);
    logic [3:0] cnt_q;
    always @(posedge mclk) begin
        if (rst || cnt_q >= period - 4'h1) cnt_q <= 4'h0;
        else cnt_q <= cnt_q + 4'h1;
    end
    assign bit_tick = !rst && cnt_q == 4'h0;
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; \
    $display("unexpected %s: expected %h seen %h", nm, e, a); end end
module testbench;
    logic mclk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, buf_we = 1'b0, tk1 = 1'b0, tk2 = 1'b0;
    logic [7:0] cmd_byte = 8'h00, cmd_wdata = 8'h00, buf_wdata = 8'h00;
    logic [5:0] buf_addr = 6'h00;
    logic [3:0] period = 4'h4;
    wire [7:0] rd_data_q;
    wire [3:0] chan_route_q;
    wire rd_valid_q, bit_tick, tx_bit_q, tx_on_q, spec_sel_q, busy;
    int n_errors = 0, checked = 0, cyc = 0;
    integer seed = 32'h587135CD;
    logic [7:0] exp_rd[$];
    logic exp_bit[$];
    cfs_sequencer uut (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .buf_we(buf_we),
        .buf_addr(buf_addr), .buf_wdata(buf_wdata), .bit_tick(bit_tick), .tx_bit_q(tx_bit_q),
        .tx_on_q(tx_on_q), .chan_route_q(chan_route_q), .spec_sel_q(spec_sel_q), .busy(busy));
    cfs_tick_model u_tick (.mclk(mclk), .rst(rst), .period(period), .bit_tick(bit_tick));
    always #2 mclk = ~mclk;
    task complete_run;
        $display("checked %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            complete_run;
        end
    end
    // Bits are sampled well after the tick so either update edge reads the same.
    always @(posedge mclk) begin
        tk1 <= bit_tick && tx_on_q;
        tk2 <= tk1;
    end
    always @(negedge mclk) begin
        if (rd_valid_q) begin
            `CHK("read data", exp_rd[0], rd_data_q)
            exp_rd.pop_front();
        end
        if (tk2 && exp_bit.size() > 0) begin
            `CHK("tx bit", exp_bit[0], tx_bit_q)
            `CHK("tx on", 1'b1, tx_on_q)
            exp_bit.pop_front();
        end
    end
    task cmd(input logic [7:0] c, input logic [7:0] d);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_byte = c;
        cmd_wdata = d;
        @(negedge mclk);
        cmd_valid = 1'b0;
    endtask
    task rd(input logic [6:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        cmd({1'b0, a}, 8'h00);
    endtask
    task send(input logic [1:0] ch, input logic [7:0] sl, ml, dl, fl, input logic mark_after_send, sp);
        logic [7:0] b;
        int nb;
        nb = dl > 64 ? 64 : dl;
        cmd(8'hAC, fl);
        cmd(8'hAD, dl);
        cmd(8'hAE, sl);
        cmd(8'hAF, ml);
        rd(7'h2D, dl);
        for (int i = 0; i < 4 * sl; i++) exp_bit.push_back(i[0]);
        for (int i = 0; i < ml; i++) exp_bit.push_back(1'b1);
        for (int i = 0; i < nb; i++) begin
            b = 8'($random(seed));
            @(negedge mclk);
            buf_we = 1'b1;
            buf_addr = i[5:0];
            buf_wdata = b;
            exp_bit.push_back(1'b0);
            for (int j = 0; j < 8; j++) exp_bit.push_back(b[j]);
            exp_bit.push_back(1'b1);
            if (i < nb - 1) for (int j = 0; j < fl; j++) exp_bit.push_back(1'b1);
        end
        @(negedge mclk);
        buf_we = 1'b0;
        cmd(8'hB0, {2'b00, ch, 1'b1, sp, mark_after_send, 1'b1});
        for (int i = 0; i < 40 && !tx_on_q; i++) @(negedge mclk);
        `CHK("route", 4'h1 << ch, chan_route_q)
        `CHK("spec", sp, spec_sel_q)
        for (int i = 0; i < 9000 && exp_bit.size() > 0; i++) @(negedge mclk);
        if (mark_after_send) begin
            for (int i = 0; i < 6; i++) exp_bit.push_back(1'b1);
            for (int i = 0; i < 90 && exp_bit.size() > 0; i++) @(negedge mclk);
            `CHK("tail on", 1'b1, tx_on_q)
            cmd(8'hB0, {2'b00, ch, 1'b1, sp, 1'b0, 1'b1});
        end
        for (int i = 0; i < 40 && busy; i++) @(negedge mclk);
        repeat (2) @(negedge mclk);
        `CHK("muted", 1'b0, tx_on_q)
        `CHK("bits left", 0, exp_bit.size())
        rd(7'h30, {2'b00, ch, 1'b1, sp, 1'b0, 1'b0});
        $display("test ended: channel %0d", ch);
    endtask
    initial begin
        repeat (16) @(negedge mclk);
        rst = 1'b0;
        for (int a = 'h2C; a <= 'h30; a++) rd(a[6:0], 8'h00);
        cmd(8'hFF, 8'h5A);
        rd(7'h7F, 8'h00);
        $display("test ended: reset values and map");
        cmd(8'hB0, 8'h09);
        repeat (4) @(negedge mclk);
        rd(7'h30, 8'h08);
        `CHK("zero run", 1'b0, tx_on_q)
        $display("test ended: zero lengths");
        cmd(8'hAD, 8'h03);
        cmd(8'hB0, 8'h01);
        repeat (8) @(negedge mclk);
        `CHK("disabled", 1'b0, tx_on_q)
        rd(7'h30, 8'h00);
        $display("test ended: block disabled");
        send(2'd0, 8'd1, 8'd2, 8'd2, 8'd0, 1'b0, 1'b0);
        period = 4'h9;
        send(2'd1, 8'd0, 8'd0, 8'd3, 8'd3, 1'b1, 1'b1);
        period = 4'h4;
        send(2'd2, 8'd2, 8'd0, 8'd200, 8'd1, 1'b0, 1'b0);
        period = 4'h9;
        send(2'd3, 8'd0, 8'd5, 8'd2, 8'd255, 1'b0, 1'b1);
        cmd(8'hB0, 8'h09);
        repeat (30) @(negedge mclk);
        `CHK("running", 1'b1, tx_on_q)
        cmd(8'hB0, 8'h00);
        repeat (3) @(negedge mclk);
        `CHK("dropped", 1'b0, tx_on_q)
        rd(7'h30, 8'h00);
        $display("test ended: disable in flight");
        cmd(8'hB0, 8'h09);
        repeat (30) @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        `CHK("reset mute", 1'b0, tx_on_q)
        rd(7'h2F, 8'h00);
        rd(7'h30, 8'h00);
        $display("test ended: reset in flight");
        repeat (4) @(negedge mclk);
        complete_run;
    end
endmodule
bind cfs_sequencer cfs_seq_asserts u_chk (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_wdata(cmd_wdata), .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q),
    .bit_tick(bit_tick), .tx_bit_q(tx_bit_q), .tx_on_q(tx_on_q), .chan_route_q(chan_route_q),
    .spec_sel_q(spec_sel_q), .busy(busy));
`default_nettype wire

// ==== hw/cfs_byte_serializer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cfs_regs.vh"

module cfs_byte_serializer (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Control
    input wire clr,
    input wire step,
    input wire [7:0] byte_in,
    // Serial view
    output wire bit_out,
    output wire last
);
    reg [3:0] pos_q;
    reg [3:0] pos_d;
    wire [9:0] frame;

    // One start bit of zero, eight data bits LSB first, one stop bit of one.
    assign frame = {1'b1, byte_in, 1'b0};
    assign bit_out = frame[pos_q];
    assign last = (pos_q == `CFS_FRAME_LAST);

    always @* begin
        pos_d = pos_q;
        if (clr) begin
            pos_d = 4'h0;
        end else if (step) begin
            pos_d = last ? 4'h0 : pos_q + 4'h1;
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            pos_q <= 4'h0;
        end else begin
            pos_q <= pos_d;
        end
    end
endmodule
`default_nettype wire

// ==== hw/cfs_regs.vh ====
`ifndef CFS_REGS_VH
`define CFS_REGS_VH

// Command byte layout: bit 7 high marks a write, bits 6:0 hold the address.
`define CFS_CMD_WR_BIT 7
`define CFS_CMD_ADDR_HI 6

// Register addresses.
`define CFS_ADDR_FLAG_LEN 7'h2C
`define CFS_ADDR_DATA_LEN 7'h2D
`define CFS_ADDR_SEIZE_LEN 7'h2E
`define CFS_ADDR_MARK_LEN 7'h2F
`define CFS_ADDR_CONTROL 7'h30

// Reset values.
`define CFS_RST_FLAG_LEN 8'h00
`define CFS_RST_DATA_LEN 8'h00
`define CFS_RST_SEIZE_LEN 8'h00
`define CFS_RST_MARK_LEN 8'h00
`define CFS_RST_CHAN 2'h0
`define CFS_RST_BIT 1'h0

// Control register field positions.
`define CFS_CTL_FCS_HI 5
`define CFS_CTL_FCS_LO 4
`define CFS_CTL_FO 3
`define CFS_CTL_BS 2
`define CFS_CTL_MAS 1
`define CFS_CTL_FS 0

// Message buffer and byte framing.
`define CFS_MAX_BYTES 7'h40
`define CFS_BUF_AW 6
`define CFS_FRAME_LAST 4'h9

`endif

// ==== hw/cfs_sequencer.v ====
`timescale 1ns/1ps
`default_nettype none
`include "cfs_regs.vh"

// Notes on behaviour
// - Flag ones between bytes, count from register
// - Send data length bytes, capped at 64
// - Seizure sends twice length zero-one pairs
// - Mark phase sends mark length ones
// - Channel select routes output to channel
// - Block runs only while enable bit set
// - Spec select picks one of two specifications
// - Mark-after-send clear: mute after message
// - Mark-after-send set: continuous ones after message
// - Clear mark-after-send with start set stops stream
// - Start begins; hardware clears it when done
// - All lengths zero: start clears immediately
module cfs_sequencer (
    // Clock and reset
    input wire mclk,
    input wire rst,
    // Command-byte control port
    input wire cmd_valid,
    input wire [7:0] cmd_byte,
    input wire [7:0] cmd_wdata,
    output reg [7:0] rd_data_q,
    output reg rd_valid_q,
    // Message buffer fill port
    input wire buf_we,
    input wire [5:0] buf_addr,
    input wire [7:0] buf_wdata,
    // Modulator side
    input wire bit_tick,
    output reg tx_bit_q,
    output reg tx_on_q,
    output reg [3:0] chan_route_q,
    output reg spec_sel_q,
    output wire busy
);
    // Phases in transmit order; the tail either mutes or keeps marking.
    localparam ST_IDLE = 3'd0;
    localparam ST_SEIZE = 3'd1;
    localparam ST_MARK = 3'd2;
    localparam ST_DATA = 3'd3;
    localparam ST_FLAG = 3'd4;
    localparam ST_TAIL = 3'd5;

    reg [7:0] flag_bit_count_q;
    reg [7:0] message_byte_count_q;
    reg [7:0] seizure_pair_half_count_q;
    reg [7:0] mark_bit_count_q;
    reg [1:0] fsk_channel_select_q;
    reg fsk_block_enable_q;
    reg spec_select_q;
    reg mark_after_send_q;
    reg fsk_start_q;
    reg fsk_start_d;
    reg [7:0] fsk_message_buffer [0:63];

    reg [2:0] state_q;
    reg [2:0] state_d;
    // Wide enough for the longest phase, four bits per seizure length step.
    reg [9:0] cnt_q;
    reg [9:0] cnt_d;
    reg [5:0] byte_idx_q;
    reg [5:0] byte_idx_d;
    reg clear_start;
    reg ser_clr;
    reg ser_step;
    reg tx_bit_d;

    wire wr_cmd;
    wire rd_cmd;
    wire [6:0] addr;
    wire ctl_wr;
    wire [6:0] n_bytes;
    wire [9:0] seize_bits;
    wire ser_bit;
    wire ser_last;
    wire [2:0] after_seize;
    wire [2:0] after_mark;

    assign addr = cmd_byte[`CFS_CMD_ADDR_HI:0];
    assign wr_cmd = cmd_valid & cmd_byte[`CFS_CMD_WR_BIT];
    assign rd_cmd = cmd_valid & ~cmd_byte[`CFS_CMD_WR_BIT];
    assign ctl_wr = wr_cmd & (addr == `CFS_ADDR_CONTROL);
    assign busy = (state_q != ST_IDLE);

    // Values above the buffer size are taken as a full buffer.
    assign n_bytes = (message_byte_count_q > {1'b0, `CFS_MAX_BYTES}) ? `CFS_MAX_BYTES :
        message_byte_count_q[6:0];
    // Each pair counts twice, and each pair is two bits.
    assign seize_bits = {seizure_pair_half_count_q, 2'b00};

    // Phase skipping for zero lengths.
    assign after_mark = (n_bytes != 7'h00) ? ST_DATA : ST_TAIL;
    assign after_seize = (mark_bit_count_q != 8'h00) ? ST_MARK : after_mark;

    // Register writes and reads.
    always @(posedge mclk) begin
        if (rst) begin
            flag_bit_count_q <= `CFS_RST_FLAG_LEN;
            message_byte_count_q <= `CFS_RST_DATA_LEN;
            seizure_pair_half_count_q <= `CFS_RST_SEIZE_LEN;
            mark_bit_count_q <= `CFS_RST_MARK_LEN;
            fsk_channel_select_q <= `CFS_RST_CHAN;
            fsk_block_enable_q <= `CFS_RST_BIT;
            spec_select_q <= `CFS_RST_BIT;
            mark_after_send_q <= `CFS_RST_BIT;
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_cmd;
            if (wr_cmd) begin
                case (addr)
                    `CFS_ADDR_FLAG_LEN: flag_bit_count_q <= cmd_wdata;
                    `CFS_ADDR_DATA_LEN: message_byte_count_q <= cmd_wdata;
                    `CFS_ADDR_SEIZE_LEN: seizure_pair_half_count_q <= cmd_wdata;
                    `CFS_ADDR_MARK_LEN: mark_bit_count_q <= cmd_wdata;
                    `CFS_ADDR_CONTROL: begin
                        fsk_channel_select_q <= cmd_wdata[`CFS_CTL_FCS_HI:`CFS_CTL_FCS_LO];
                        fsk_block_enable_q <= cmd_wdata[`CFS_CTL_FO];
                        spec_select_q <= cmd_wdata[`CFS_CTL_BS];
                        mark_after_send_q <= cmd_wdata[`CFS_CTL_MAS];
                    end
                    default: begin
                    end
                endcase
            end
            if (rd_cmd) begin
                case (addr)
                    `CFS_ADDR_FLAG_LEN: rd_data_q <= flag_bit_count_q;
                    `CFS_ADDR_DATA_LEN: rd_data_q <= message_byte_count_q;
                    `CFS_ADDR_SEIZE_LEN: rd_data_q <= seizure_pair_half_count_q;
                    `CFS_ADDR_MARK_LEN: rd_data_q <= mark_bit_count_q;
                    // Reserved bits 7:6 read back as zero.
                    `CFS_ADDR_CONTROL: rd_data_q <= {2'b00, fsk_channel_select_q,
                        fsk_block_enable_q, spec_select_q, mark_after_send_q, fsk_start_q};
                    default: rd_data_q <= 8'h00;
                endcase
            end
        end
    end

    // The buffer has no reset; software fills it before starting.
    always @(posedge mclk) begin
        if (buf_we) begin
            fsk_message_buffer[buf_addr] <= buf_wdata;
        end
    end

    // A host write that sets the start bit wins over a hardware clear in the same cycle.
    always @* begin
        fsk_start_d = fsk_start_q;
        if (clear_start) begin
            fsk_start_d = 1'b0;
        end
        if (ctl_wr) begin
            fsk_start_d = cmd_wdata[`CFS_CTL_FS] | (fsk_start_q & ~clear_start);
        end
    end

    // The serializer steps only on data-phase ticks, so it waits at its start bit
    // through the seizure and mark phases.
    cfs_byte_serializer u_ser (
        .mclk(mclk),
        .rst(rst),
        .clr(ser_clr),
        .step(ser_step),
        .byte_in(fsk_message_buffer[byte_idx_q]),
        .bit_out(ser_bit),
        .last(ser_last)
    );

    always @* begin
        state_d = state_q;
        cnt_d = cnt_q;
        byte_idx_d = byte_idx_q;
        clear_start = 1'b0;
        ser_clr = 1'b0;
        ser_step = 1'b0;
        tx_bit_d = tx_bit_q;
        if (!fsk_block_enable_q) begin
            // Disabling drops any transfer in flight.
            state_d = ST_IDLE;
            clear_start = fsk_start_q;
            ser_clr = 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cnt_d = 10'h000;
                    byte_idx_d = 6'h00;
                    ser_clr = 1'b1;
                    if (fsk_start_q) begin
                        // Nothing to send: drop the start bit and stay muted.
                        if (seize_bits == 10'h000 && mark_bit_count_q == 8'h00 &&
                            n_bytes == 7'h00) begin
                            clear_start = 1'b1;
                        end else if (seize_bits != 10'h000) begin
                            state_d = ST_SEIZE;
                        end else begin
                            state_d = after_seize;
                        end
                    end
                end
                ST_SEIZE: begin
                    if (bit_tick) begin
                        tx_bit_d = cnt_q[0];
                        cnt_d = cnt_q + 10'h001;
                        if (cnt_q == seize_bits - 10'h001) begin
                            cnt_d = 10'h000;
                            state_d = after_seize;
                        end
                    end
                end
                ST_MARK: begin
                    if (bit_tick) begin
                        tx_bit_d = 1'b1;
                        cnt_d = cnt_q + 10'h001;
                        if (cnt_q[7:0] == mark_bit_count_q - 8'h01) begin
                            cnt_d = 10'h000;
                            state_d = after_mark;
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_tick) begin
                        tx_bit_d = ser_bit;
                        ser_step = 1'b1;
                        if (ser_last) begin
                            if ({1'b0, byte_idx_q} == n_bytes - 7'h01) begin
                                state_d = ST_TAIL;
                            end else begin
                                byte_idx_d = byte_idx_q + 6'h01;
                                // Flag runs go only between bytes, never after the last one.
                                if (flag_bit_count_q != 8'h00) begin
                                    state_d = ST_FLAG;
                                end
                            end
                        end
                    end
                end
                ST_FLAG: begin
                    // The counter is shared by the counted phases and is zero on entry to each.
                    if (bit_tick) begin
                        tx_bit_d = 1'b1;
                        cnt_d = cnt_q + 10'h001;
                        if (cnt_q[7:0] == flag_bit_count_q - 8'h01) begin
                            cnt_d = 10'h000;
                            state_d = ST_DATA;
                        end
                    end
                end
                ST_TAIL: begin
                    // Start is cleared on entry, so a set start here is a fresh host write.
                    if (fsk_start_q && !mark_after_send_q) begin
                        state_d = ST_IDLE;
                        clear_start = 1'b1;
                    end else if (bit_tick) begin
                        if (mark_after_send_q) begin
                            tx_bit_d = 1'b1;
                        end else begin
                            // Waiting one tick lets the last stop bit run its full period
                            // before the output is muted.
                            state_d = ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
            if (state_d == ST_TAIL && state_q != ST_TAIL) begin
                clear_start = 1'b1;
            end
        end
    end

    always @(posedge mclk) begin
        if (rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 10'h000;
            byte_idx_q <= 6'h00;
            fsk_start_q <= `CFS_RST_BIT;
            // The line rests at one, so a muted modulator is left on mark.
            tx_bit_q <= 1'b1;
            tx_on_q <= 1'b0;
            chan_route_q <= 4'h0;
            spec_sel_q <= `CFS_RST_BIT;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            byte_idx_q <= byte_idx_d;
            fsk_start_q <= fsk_start_d;
            tx_bit_q <= tx_bit_d;
            // Output is muted whenever no phase is running.
            tx_on_q <= (state_d != ST_IDLE);
            chan_route_q <= (state_d != ST_IDLE) ?
                (4'h1 << fsk_channel_select_q) : 4'h0;
            // Route is registered from the next state; spec select is registered from its bit every cycle, busy or idle.
            spec_sel_q <= spec_select_q;
        end
    end
endmodule
`default_nettype wire
